// >>> sim/bbcsi_engine_checker.sv
// Concurrent checks on the command engine ports.
// Assumes a bind onto bbcsi_engine with its address width passed on.
`timescale 1ns/10ps
`default_nettype none
module bbcsi_engine_checker
  import bbcsi_pkg::*;
#(parameter int ADDR_W = ADDR_W_DEF) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic [2:0] bootPhase,
  input wire logic flashBusy,
  input wire logic [ERR_CAUSES-1:0] errEvent,
  input wire logic errClear,
  input wire logic [7:0] flashRdData,
  input wire logic txReady,
  input wire logic [ADDR_W-1:0] flashRdAddr,
  input wire logic flashRdEn,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic cmdBusy,
  input wire logic [7:0] errCode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence sTake(logic [7:0] c);
    rxValid && !cmdBusy && rxData == c;
  endsequence
  sequence sInqTake;
    sTake(CMD_INQUIRY);
  endsequence
  chk_blank_start: assert property (sTake(CMD_BLANK) |=>
    cmdBusy ##1 (flashRdEn && flashRdAddr == '0))
    else $error("Blank check did not start reading");
  chk_inq_reply: assert property (sInqTake ##0 !flashBusy
    ##1 !flashBusy |-> ##2 (txValid && txData == RSP_INQUIRY))
    else $error("Inquiry reply late or wrong");
  chk_inq_status: assert property (sInqTake ##0 !flashBusy
    ##1 (!flashBusy && bootPhase == PH_DEV_SEL) ##2 txReady[*2] |=>
    (txValid && txData == ST_DEV_SEL))
    else $error("Device selection status wrong");
  chk_busy_defer: assert property (sInqTake ##0 flashBusy
    ##1 flashBusy[*2] |=> !txValid)
    else $error("Inquiry answered during flash work");
  chk_tx_hold: assert property (txValid && !txReady |=>
    txValid && $stable(txData))
    else $error("Reply byte not held");
  chk_idle_silent: assert property (!cmdBusy |-> !txValid)
    else $error("Reply byte while idle");
  chk_err_clear: assert property (errClear && errEvent == '0 |=>
    errCode == ER_NONE)
    else $error("Error code not cleared");
  chk_err_sum: assert property (errEvent == 17'h00001 |=>
    errCode == ER_SUM)
    else $error("Sum check code wrong");
  chk_err_dev: assert property (errEvent == 17'h00004 |=>
    errCode == ER_DEV_CODE)
    else $error("Device code error wrong");
  chk_err_keep: assert property (errEvent == '0 && !errClear
    && !cmdBusy |=> $stable(errCode))
    else $error("Error code changed by itself");
endmodule
bind bbcsi_engine bbcsi_engine_checker #(.ADDR_W(ADDR_W)) chk (
  .sys_clk(sys_clk), .resetn(resetn), .rxValid(rxValid), .rxData(rxData),
  .bootPhase(bootPhase), .flashBusy(flashBusy), .errEvent(errEvent),
  .errClear(errClear), .flashRdData(flashRdData), .txReady(txReady),
  .flashRdAddr(flashRdAddr), .flashRdEn(flashRdEn), .txValid(txValid),
  .txData(txData), .cmdBusy(cmdBusy), .errCode(errCode));
`default_nettype wire

// >>> sim/bbcsi_flash_model.sv
// Flash array read port model, one cycle of latency.
// Assumes one byte may be made non-blank by the bench.
`timescale 1ns/10ps
`default_nettype none
module bbcsi_flash_model #(parameter int AW = 4) (
  input wire logic sys_clk,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  input wire logic [AW-1:0] dirtyAddr,
  input wire logic dirtyOn,
  output logic [7:0] rdData = 8'h5A
);
  always_ff @(posedge sys_clk) begin
    if (rdEn && dirtyOn && rdAddr == dirtyAddr) begin
      rdData <= 8'h7E;
    end else if (rdEn) begin
      rdData <= 8'hFF;
    end else begin
      rdData <= ~rdData;
    end
  end
endmodule
`default_nettype wire

// >>> sim/boot_blank_check_state_inquiry_test.sv
// Self-checking bench for the blank check and state inquiry engine.
// Assumes a 16-byte flash model and a transmitter that is ready except for one stall in the status test.
`timescale 1ns/10ps
`default_nettype none
module boot_blank_check_state_inquiry_test import bbcsi_pkg::*;;
  logic sysClk = 1'h0;
  logic resetn = 1'h0;
  logic rxValid = 1'h0;
  logic [7:0] rxData = 8'h00;
  logic [2:0] bootPhase = 3'h0;
  logic flashBusy = 1'h0;
  logic [ERR_CAUSES-1:0] errEvent = '0;
  logic errClear = 1'h0;
  logic txReady = 1'h1;
  logic dirtyOn = 1'h0;
  logic [7:0] flashRdData, txData, errCode;
  logic [3:0] flashRdAddr;
  logic flashRdEn, txValid, cmdBusy;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] codes [17] = '{ER_SUM, ER_PROG_SIZE, ER_DEV_CODE, ER_CLK_MODE,
    ER_BIT_RATE, ER_IN_FREQ, ER_MULT, ER_OP_FREQ, ER_BLOCK, ER_ADDR,
    ER_LENGTH, ER_ERASE, ER_NOT_BLANK, ER_PROGRAM, ER_SELECT, ER_COMMAND,
    ER_RATE_CONF};
  logic [7:0] stats [8] = '{ST_DEV_SEL, ST_CLK_SEL, ST_RATE_SEL,
    ST_PE_TRANS, ST_PROG_ERASE, ST_PE_SEL, ST_PROG_DATA, ST_ERASE_BLK};
  bbcsi_engine #(.ADDR_W(4), .FLASH_BYTES(16)) uut (.sys_clk(sysClk),
    .resetn(resetn), .rxValid(rxValid), .rxData(rxData),
    .bootPhase(bootPhase), .flashBusy(flashBusy), .errEvent(errEvent),
    .errClear(errClear), .flashRdData(flashRdData), .txReady(txReady),
    .flashRdAddr(flashRdAddr), .flashRdEn(flashRdEn), .txValid(txValid),
    .txData(txData), .cmdBusy(cmdBusy), .errCode(errCode));
  bbcsi_flash_model #(.AW(4)) flash (.sys_clk(sysClk), .rdEn(flashRdEn),
    .rdAddr(flashRdAddr), .dirtyAddr(4'hF), .dirtyOn(dirtyOn),
    .rdData(flashRdData));
  always #25 sysClk = ~sysClk;
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge sysClk);
    rxValid <= 1'h1;
    rxData <= b;
    @(posedge sysClk);
    rxValid <= 1'h0;
  endtask
  task automatic expect_byte(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge sysClk);
    while (txValid !== 1'h1 && n < 200) begin
      n++;
      @(negedge sysClk);
    end
    check({7'h00, txValid}, 8'h01);
    check(txData, exp);
    @(posedge sysClk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cmdBusy !== 1'h0 && n < 50) begin
      n++;
      @(negedge sysClk);
    end
    check({7'h00, cmdBusy}, 8'h00);
  endtask
  task automatic clear_err();
    @(posedge sysClk);
    errClear <= 1'h1;
    @(posedge sysClk);
    errClear <= 1'h0;
    @(negedge sysClk);
    check(errCode, ER_NONE);
  endtask
  task automatic inquiry(input logic [2:0] ph, input logic [7:0] st, er,
      input int busyCycles);
    @(posedge sysClk);
    bootPhase <= ph;
    flashBusy <= (busyCycles > 0);
    send(CMD_INQUIRY);
    if (busyCycles > 0) begin
      repeat (busyCycles) @(negedge sysClk);
      check({7'h00, txValid}, 8'h00);
      @(posedge sysClk);
      flashBusy <= 1'h0;
    end
    expect_byte(RSP_INQUIRY);
    expect_byte(INQ_SIZE);
    expect_byte(st);
    expect_byte(er);
    expect_byte(8'h00 - RSP_INQUIRY - INQ_SIZE - st - er);
    wait_idle();
  endtask
  task automatic test_blank();
    send(CMD_BLANK);
    expect_byte(RSP_ACK);
    wait_idle();
    @(posedge sysClk);
    dirtyOn <= 1'h1;
    send(CMD_BLANK);
    expect_byte(RSP_BLANK_ERR);
    expect_byte(ER_NOT_BLANK);
    wait_idle();
    check(errCode, ER_NOT_BLANK);
    inquiry(PH_PE_SEL, ST_PE_SEL, ER_NOT_BLANK, 0);
    dirtyOn <= 1'h0;
    clear_err();
  endtask
  task automatic test_status();
    for (int i = 0; i < 8; i++) begin
      inquiry(3'(i), stats[i], ER_NONE, 0);
    end
    inquiry(PH_PROG_ERASE, ST_PROG_ERASE, ER_NONE, 12);
    @(posedge sysClk);
    txReady <= 1'h0;
    bootPhase <= PH_PE_SEL;
    send(CMD_INQUIRY);
    repeat (6) @(negedge sysClk);
    check({7'h00, txValid}, 8'h01);
    check(txData, RSP_INQUIRY);
    @(posedge sysClk);
    txReady <= 1'h1;
    expect_byte(RSP_INQUIRY);
    expect_byte(INQ_SIZE);
    expect_byte(ST_PE_SEL);
    expect_byte(ER_NONE);
    expect_byte(8'h00 - RSP_INQUIRY - INQ_SIZE - ST_PE_SEL);
    wait_idle();
  endtask
  task automatic test_errors();
    for (int i = 0; i < ERR_CAUSES; i++) begin
      @(posedge sysClk);
      errEvent[i] <= 1'h1;
      @(posedge sysClk);
      errEvent <= '0;
      @(negedge sysClk);
      check(errCode, codes[i]);
    end
    inquiry(PH_ERASE_BLK, ST_ERASE_BLK, ER_RATE_CONF, 0);
    @(posedge sysClk);
    errEvent[EI_SUM] <= 1'h1;
    errClear <= 1'h1;
    @(posedge sysClk);
    errEvent <= '0;
    errClear <= 1'h0;
    @(negedge sysClk);
    check(errCode, ER_SUM);
    clear_err();
  endtask
  initial begin
    repeat (5) @(posedge sysClk);
    resetn <= 1'h1;
    test_blank();
    test_status();
    test_errors();
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> src/bbcsi_engine.sv
// Blank check and state inquiry command answering engine.
// Assumes bytes arrive as one-cycle strobes from a link receiver on
// sys_clk, a flash read port with fixed one-cycle latency, and a
// transmitter that takes a byte per txValid while txReady is high.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Command byte 4D alone asks for a blank check of all flash arrays.
// - If every flash byte reads FF the answer is the single byte 06.
// - If any flash byte is not FF the answer is CD then error code 52.
// - Command 4F is accepted in every boot phase while the engine is idle.
// - Inquiry reply is 5F, size 2, status, error, then checksum.
// - The error byte is zero when normal and nonzero on any fault.
// - An inquiry during program or erase is held and answered late.
// - Status reads 11, 12, 13 in the device, clock and rate waits.
// - Status reads 1F after rate selection until program/erase entry.
// - Status reads 31 in erase programming and 3F in selection wait.
// - Status reads 4F awaiting program data and 5F awaiting a block.
// - Device code mismatch gives 21 and clock mode mismatch gives 22.
// - Rate gives 24, input frequency 25, ratio 26, operating freq 27.
// - A checksum mismatch gives sum check error code 11.
module bbcsi_engine
  import bbcsi_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int FLASH_BYTES = 1 << ADDR_W_DEF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic [2:0] bootPhase,
  input wire logic flashBusy,
  input wire logic [ERR_CAUSES-1:0] errEvent,
  input wire logic errClear,
  input wire logic [7:0] flashRdData,
  input wire logic txReady,
  output logic [ADDR_W-1:0] flashRdAddr,
  output logic flashRdEn,
  output logic txValid,
  output logic [7:0] txData,
  output logic cmdBusy,
  output logic [7:0] errCode
);

  // Refuse geometries the address counter cannot cover
  if (ADDR_W < 1 || ADDR_W > 31 || FLASH_BYTES < 1 ||
      FLASH_BYTES > (1 << ADDR_W)) begin : g_bad_geometry
    $error("bbcsi_engine: bad flash geometry");
  end

  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(FLASH_BYTES - 1);

  bbcsi_state_type state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic rdEn_reg, rdEn_next;
  logic lastRd_reg, lastRd_next;
  logic vld_reg, vld_next;
  logic dirty_reg, dirty_next;
  logic [7:0] buf_reg [0:4];
  logic [7:0] buf_next [0:4];
  logic [2:0] count_reg, count_next;
  logic [2:0] idx_reg, idx_next;
  logic txValid_reg, txValid_next;
  logic [7:0] txData_reg, txData_next;
  logic busy_reg, busy_next;
  logic pendInq_reg, pendInq_next;
  logic [7:0] err_reg, err_next;
  logic [7:0] status;
  logic [7:0] evCode;

  // Status code from boot phase
  always_comb begin
    case (bootPhase)
      PH_DEV_SEL: status = ST_DEV_SEL;
      PH_CLK_SEL: status = ST_CLK_SEL;
      PH_RATE_SEL: status = ST_RATE_SEL;
      PH_PE_TRANS: status = ST_PE_TRANS;
      PH_PROG_ERASE: status = ST_PROG_ERASE;
      PH_PE_SEL: status = ST_PE_SEL;
      PH_PROG_DATA: status = ST_PROG_DATA;
      PH_ERASE_BLK: status = ST_ERASE_BLK;
      default: status = ST_DEV_SEL;
    endcase
  end

  // Error event to code, lowest index wins
  always_comb begin
    evCode = ER_NONE;
    for (int i = ERR_CAUSES - 1; i >= 0; i--) begin
      if (errEvent[i]) begin
        case (i)
          EI_SUM: evCode = ER_SUM;
          EI_PROG_SIZE: evCode = ER_PROG_SIZE;
          EI_DEV_CODE: evCode = ER_DEV_CODE;
          EI_CLK_MODE: evCode = ER_CLK_MODE;
          EI_BIT_RATE: evCode = ER_BIT_RATE;
          EI_IN_FREQ: evCode = ER_IN_FREQ;
          EI_MULT: evCode = ER_MULT;
          EI_OP_FREQ: evCode = ER_OP_FREQ;
          EI_BLOCK: evCode = ER_BLOCK;
          EI_ADDR: evCode = ER_ADDR;
          EI_LENGTH: evCode = ER_LENGTH;
          EI_ERASE: evCode = ER_ERASE;
          EI_NOT_BLANK: evCode = ER_NOT_BLANK;
          EI_PROGRAM: evCode = ER_PROGRAM;
          EI_SELECT: evCode = ER_SELECT;
          EI_COMMAND: evCode = ER_COMMAND;
          EI_RATE_CONF: evCode = ER_RATE_CONF;
          default: evCode = ER_COMMAND;
        endcase
      end
    end
  end

  // Command engine next state
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    rdEn_next = 1'b0;
    lastRd_next = 1'b0;
    vld_next = 1'b0;
    dirty_next = dirty_reg;
    for (int i = 0; i < 5; i++) buf_next[i] = buf_reg[i];
    count_next = count_reg;
    idx_next = idx_reg;
    txValid_next = txValid_reg;
    txData_next = txData_reg;
    busy_next = busy_reg;
    pendInq_next = pendInq_reg;
    err_next = err_reg;
    // New event wins over a clear in the same cycle
    if (errEvent != '0)
      err_next = evCode;
    else if (errClear)
      err_next = ER_NONE;
    case (state_reg)
      BB_IDLE: begin
        if (rxValid && rxData == CMD_BLANK) begin
          addr_next = '0;
          dirty_next = 1'b0;
          busy_next = 1'b1;
          state_next = BB_SCAN;
        end else if (rxValid && rxData == CMD_INQUIRY) begin
          busy_next = 1'b1;
          pendInq_next = 1'b1;
          state_next = BB_WAIT;
        end
      end
      BB_SCAN: begin
        // Read data stands one cycle after its strobe
        if (vld_reg && flashRdData != ERASED_BYTE)
          dirty_next = 1'b1;
        if (vld_reg && lastRd_reg) begin
          if (dirty_reg || flashRdData != ERASED_BYTE) begin
            buf_next[0] = RSP_BLANK_ERR;
            buf_next[1] = ER_NOT_BLANK;
            count_next = 3'd2;
            err_next = ER_NOT_BLANK;
          end else begin
            buf_next[0] = RSP_ACK;
            count_next = 3'd1;
          end
          idx_next = '0;
          state_next = BB_SEND;
        end else if (rdEn_reg) begin
          vld_next = 1'b1;
          lastRd_next = (addr_reg == LAST_ADDR);
          if (addr_reg != LAST_ADDR) begin
            rdEn_next = 1'b1;
            addr_next = addr_reg + 1'b1;
          end
        end else if (!vld_reg) begin
          rdEn_next = 1'b1;
        end
      end
      BB_WAIT: begin
        if (!flashBusy) begin
          buf_next[0] = RSP_INQUIRY;
          buf_next[1] = INQ_SIZE;
          buf_next[2] = status;
          buf_next[3] = err_next;
          buf_next[4] = 8'(8'h00 - (RSP_INQUIRY + INQ_SIZE + status +
            err_next));
          count_next = 3'd5;
          idx_next = '0;
          pendInq_next = 1'b0;
          state_next = BB_SEND;
        end
      end
      BB_SEND: begin
        if (!txValid_reg || txReady) begin
          if (idx_reg == count_reg) begin
            txValid_next = 1'b0;
            busy_next = 1'b0;
            state_next = BB_IDLE;
          end else begin
            txValid_next = 1'b1;
            txData_next = buf_reg[idx_reg];
            idx_next = idx_reg + 3'd1;
          end
        end
      end
      default: begin
        state_next = BB_IDLE;
        txValid_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= BB_IDLE;
      addr_reg <= '0;
      rdEn_reg <= 1'b0;
      lastRd_reg <= 1'b0;
      vld_reg <= 1'b0;
      dirty_reg <= 1'b0;
      for (int i = 0; i < 5; i++) buf_reg[i] <= 8'h00;
      count_reg <= 3'd0;
      idx_reg <= 3'd0;
      txValid_reg <= 1'b0;
      txData_reg <= 8'h00;
      busy_reg <= 1'b0;
      pendInq_reg <= 1'b0;
      err_reg <= ER_NONE;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      rdEn_reg <= rdEn_next;
      lastRd_reg <= lastRd_next;
      vld_reg <= vld_next;
      dirty_reg <= dirty_next;
      for (int i = 0; i < 5; i++) buf_reg[i] <= buf_next[i];
      count_reg <= count_next;
      idx_reg <= idx_next;
      txValid_reg <= txValid_next;
      txData_reg <= txData_next;
      busy_reg <= busy_next;
      pendInq_reg <= pendInq_next;
      err_reg <= err_next;
    end
  end

  assign flashRdAddr = addr_reg;
  assign flashRdEn = rdEn_reg;
  assign txValid = txValid_reg;
  assign txData = txData_reg;
  assign cmdBusy = busy_reg;
  assign errCode = err_reg;

endmodule
`default_nettype wire

// >>> src/bbcsi_pkg.sv
// Constants for the blank check and state inquiry command block.
// Assumes a byte-wide command/response link on one system clock.
package bbcsi_pkg;
  localparam logic [7:0] CMD_BLANK = 8'h4D;
  localparam logic [7:0] CMD_INQUIRY = 8'h4F;
  localparam logic [7:0] RSP_ACK = 8'h06;
  localparam logic [7:0] RSP_BLANK_ERR = 8'hCD;
  localparam logic [7:0] RSP_INQUIRY = 8'h5F;
  localparam logic [7:0] RSP_CMD_ERR = 8'h80;
  localparam logic [7:0] INQ_SIZE = 8'h02;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Status codes
  localparam logic [7:0] ST_DEV_SEL = 8'h11;
  localparam logic [7:0] ST_CLK_SEL = 8'h12;
  localparam logic [7:0] ST_RATE_SEL = 8'h13;
  localparam logic [7:0] ST_PE_TRANS = 8'h1F;
  localparam logic [7:0] ST_PROG_ERASE = 8'h31;
  localparam logic [7:0] ST_PE_SEL = 8'h3F;
  localparam logic [7:0] ST_PROG_DATA = 8'h4F;
  localparam logic [7:0] ST_ERASE_BLK = 8'h5F;
  // Error codes
  localparam logic [7:0] ER_NONE = 8'h00;
  localparam logic [7:0] ER_SUM = 8'h11;
  localparam logic [7:0] ER_PROG_SIZE = 8'h12;
  localparam logic [7:0] ER_DEV_CODE = 8'h21;
  localparam logic [7:0] ER_CLK_MODE = 8'h22;
  localparam logic [7:0] ER_BIT_RATE = 8'h24;
  localparam logic [7:0] ER_IN_FREQ = 8'h25;
  localparam logic [7:0] ER_MULT = 8'h26;
  localparam logic [7:0] ER_OP_FREQ = 8'h27;
  localparam logic [7:0] ER_BLOCK = 8'h29;
  localparam logic [7:0] ER_ADDR = 8'h2A;
  localparam logic [7:0] ER_LENGTH = 8'h2B;
  localparam logic [7:0] ER_ERASE = 8'h51;
  localparam logic [7:0] ER_NOT_BLANK = 8'h52;
  localparam logic [7:0] ER_PROGRAM = 8'h53;
  localparam logic [7:0] ER_SELECT = 8'h54;
  localparam logic [7:0] ER_COMMAND = 8'h80;
  localparam logic [7:0] ER_RATE_CONF = 8'hFF;
  // Error cause indices on the error event bus
  localparam int ERR_CAUSES = 17;
  localparam int EI_SUM = 0;
  localparam int EI_PROG_SIZE = 1;
  localparam int EI_DEV_CODE = 2;
  localparam int EI_CLK_MODE = 3;
  localparam int EI_BIT_RATE = 4;
  localparam int EI_IN_FREQ = 5;
  localparam int EI_MULT = 6;
  localparam int EI_OP_FREQ = 7;
  localparam int EI_BLOCK = 8;
  localparam int EI_ADDR = 9;
  localparam int EI_LENGTH = 10;
  localparam int EI_ERASE = 11;
  localparam int EI_NOT_BLANK = 12;
  localparam int EI_PROGRAM = 13;
  localparam int EI_SELECT = 14;
  localparam int EI_COMMAND = 15;
  localparam int EI_RATE_CONF = 16;
  // Boot phase encoding on the phase input
  localparam logic [2:0] PH_DEV_SEL = 3'h0;
  localparam logic [2:0] PH_CLK_SEL = 3'h1;
  localparam logic [2:0] PH_RATE_SEL = 3'h2;
  localparam logic [2:0] PH_PE_TRANS = 3'h3;
  localparam logic [2:0] PH_PROG_ERASE = 3'h4;
  localparam logic [2:0] PH_PE_SEL = 3'h5;
  localparam logic [2:0] PH_PROG_DATA = 3'h6;
  localparam logic [2:0] PH_ERASE_BLK = 3'h7;
  localparam int ADDR_W_DEF = 16;
  typedef enum logic [2:0] {
    BB_IDLE, BB_SCAN, BB_WAIT, BB_SEND, BB_HOLD
  } bbcsi_state_type;
endpackage
